/* File: isf_pkg.sv */
// Constants and register layout for the I2C status flag block
package isf_pkg;
  localparam logic [15:0] STATUS_ADDR = 16'hffa9;
  localparam logic [15:0] CONTROL_ADDR = 16'hffa8;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Status bit positions
  localparam int MASTER_BIT = 7;
  localparam int ARB_BIT = 6;
  localparam int EXT_BIT = 5;
  localparam int MATCH_BIT = 4;
  localparam int TX_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int START_BIT = 1;
  localparam int STOP_BIT = 0;
  // Control bit positions
  localparam int ENABLE_BIT = 7;
  localparam int EXIT_BIT = 6;
  localparam int WREL_BIT = 5;
  localparam int STOPREQ_BIT = 0;
  // Serial clock counts
  localparam logic [3:0] ADDR_CLK = 4'h8;
  localparam logic [3:0] ACK_CLK = 4'h9;
endpackage

/* File: isf_status.sv */
// I2C status flag register with bus event detection
module isf_status (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_bit,
  input wire logic [7:0] cpu_wdata,
  input wire logic [6:0] own_slave_address,
  input wire logic start_generated,
  input wire logic arb_lost,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic [7:0] cpu_rdata_r,
  output logic stop_request_r,
  output logic data_drive_en_r,
  output logic enable_r
);
  logic [2:0] scl_s_r, sda_s_r;
  logic scl_f_r, sda_f_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] clk_cnt_r;
  logic first_byte_r;
  logic [7:0] addr_sh_r;
  logic exit_r, wrel_r, enable_fall;
  logic master_active_flag_r, arbitration_lost_flag_r, extension_code_flag_r;
  logic address_match_flag_r, transmit_state_flag_r, ack_detected_flag_r;
  logic start_detected_flag_r, stop_detected_flag_r;
  logic [7:0] status;
  logic ctl_wr, stat_rd, other_bit, eighth, ninth, clr_common;

  // Three-stage pin synchronisers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
    end
  end

  // Accept level once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
    end
  end

  // Bus edges and conditions
  assign scl_rise = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_f_r;
  assign scl_fall = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_f_r;
  assign start_det = enable_r && scl_f_r && sda_f_r && (sda_s_r[1] == sda_s_r[2])
    && !sda_s_r[2];
  assign stop_det = enable_r && scl_f_r && !sda_f_r && (sda_s_r[1] == sda_s_r[2])
    && sda_s_r[2];
  assign eighth = enable_r && scl_rise && clk_cnt_r == isf_pkg::ADDR_CLK - 4'h1;
  assign ninth = enable_r && scl_rise && clk_cnt_r == isf_pkg::ADDR_CLK;

  // CPU access decode
  assign ctl_wr = cpu_wr && cpu_addr == isf_pkg::CONTROL_ADDR;
  assign stat_rd = cpu_rd && cpu_addr == isf_pkg::STATUS_ADDR;
  assign other_bit = cpu_bit && cpu_addr != isf_pkg::STATUS_ADDR;
  assign enable_fall = ctl_wr && enable_r && !cpu_wdata[isf_pkg::ENABLE_BIT];
  assign clr_common = exit_r || enable_fall;

  // Serial clock counter; holds nine through the wait after the ninth clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_cnt_r <= 4'h0;
      first_byte_r <= 1'b0;
    end else if (start_det || stop_det || !enable_r) begin
      clk_cnt_r <= 4'h0;
      first_byte_r <= start_det;
    end else if (scl_rise) begin
      clk_cnt_r <= (clk_cnt_r == isf_pkg::ACK_CLK) ? 4'h1 : clk_cnt_r + 4'h1;
    end else if (scl_fall && clk_cnt_r == isf_pkg::ACK_CLK) begin
      first_byte_r <= 1'b0;
    end
  end

  // Received address shifter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) addr_sh_r <= 8'h00;
    else if (scl_rise && first_byte_r) addr_sh_r <= {addr_sh_r[6:0], sda_f_r};
  end

  // Control register; exit and wait release self-clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= isf_pkg::CONTROL_RESET[isf_pkg::ENABLE_BIT];
      exit_r <= 1'b0;
      wrel_r <= 1'b0;
      stop_request_r <= 1'b0;
    end else begin
      if (ctl_wr) enable_r <= cpu_wdata[isf_pkg::ENABLE_BIT];
      exit_r <= ctl_wr && cpu_wdata[isf_pkg::EXIT_BIT];
      wrel_r <= ctl_wr && cpu_wdata[isf_pkg::WREL_BIT];
      stop_request_r <= ctl_wr && cpu_wdata[isf_pkg::STOPREQ_BIT]
        && master_active_flag_r;
    end
  end

  // Master active flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) master_active_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::MASTER_BIT];
    else if (stop_det || arb_lost || clr_common) master_active_flag_r <= 1'b0;
    else if (start_generated && enable_r) master_active_flag_r <= 1'b1;
  end

  // Arbitration lost flag; a new loss beats the read clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) arbitration_lost_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::ARB_BIT];
    else if (arb_lost && enable_r) arbitration_lost_flag_r <= 1'b1;
    else if (stat_rd || other_bit || enable_fall) arbitration_lost_flag_r <= 1'b0;
  end

  // Extension code and address match flags
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      extension_code_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::EXT_BIT];
      address_match_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::MATCH_BIT];
    end else if (start_det || stop_det || clr_common) begin
      extension_code_flag_r <= 1'b0;
      address_match_flag_r <= 1'b0;
    end else if (eighth && first_byte_r) begin
      if (addr_sh_r[6:3] == 4'h0 || addr_sh_r[6:3] == 4'hf)
        extension_code_flag_r <= 1'b1;
      if (addr_sh_r[6:0] == own_slave_address)
        address_match_flag_r <= 1'b1;
    end
  end

  // Transmit state; wait release in ninth clock ends it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) transmit_state_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::TX_BIT];
    else if (start_det || stop_det || clr_common || arb_lost) transmit_state_flag_r <= 1'b0;
    else if (wrel_r && clk_cnt_r == isf_pkg::ACK_CLK) transmit_state_flag_r <= 1'b0;
    else if (eighth && first_byte_r)
      transmit_state_flag_r <= master_active_flag_r ? !sda_f_r
        : (addr_sh_r[6:0] == own_slave_address) && sda_f_r;
  end

  // Data line drive follows transmit state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) data_drive_en_r <= 1'b0;
    else data_drive_en_r <= transmit_state_flag_r && !(wrel_r
      && clk_cnt_r == isf_pkg::ACK_CLK);
  end

  // Acknowledge, start and stop detection flags
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_detected_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::ACK_BIT];
      start_detected_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::START_BIT];
      stop_detected_flag_r <= isf_pkg::STATUS_RESET[isf_pkg::STOP_BIT];
    end else if (clr_common) begin
      ack_detected_flag_r <= 1'b0;
      start_detected_flag_r <= 1'b0;
      stop_detected_flag_r <= 1'b0;
    end else begin
      if (start_det || stop_det) ack_detected_flag_r <= 1'b0;
      else if (ninth) ack_detected_flag_r <= !sda_f_r;
      if (start_det) start_detected_flag_r <= 1'b1;
      else if (stop_det) start_detected_flag_r <= 1'b0;
      if (stop_det) stop_detected_flag_r <= 1'b1;
      else if (start_det) stop_detected_flag_r <= 1'b0;
    end
  end

  assign status = {master_active_flag_r, arbitration_lost_flag_r, extension_code_flag_r,
    address_match_flag_r, transmit_state_flag_r, ack_detected_flag_r,
    start_detected_flag_r, stop_detected_flag_r};

  // Read data; status is read-only, stop request reads 0
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cpu_rdata_r <= 8'h00;
    else if (stat_rd) cpu_rdata_r <= status;
    else if (cpu_rd && cpu_addr == isf_pkg::CONTROL_ADDR)
      cpu_rdata_r <= {enable_r, 7'h00};
    else if (cpu_rd) cpu_rdata_r <= 8'h00;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_master_set;
    start_generated && enable_r && !stop_det && !arb_lost && !clr_common
      |=> master_active_flag_r;
  endproperty
  a_master_set: assert property (p_master_set) else $error("master flag not set");
  property p_master_clr;
    stop_det || arb_lost || clr_common |=> !master_active_flag_r;
  endproperty
  a_master_clr: assert property (p_master_clr) else $error("master flag not cleared");
  property p_arb_set;
    arb_lost && enable_r |=> arbitration_lost_flag_r && !master_active_flag_r;
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("loss flag wrong");
  property p_arb_rdclr;
    (stat_rd || other_bit) && !(arb_lost && enable_r) |=> !arbitration_lost_flag_r;
  endproperty
  a_arb_rdclr: assert property (p_arb_rdclr) else $error("loss flag kept");
  property p_bit_other;
    other_bit && !arb_lost ##1 1 |-> !arbitration_lost_flag_r;
  endproperty
  a_bit_other: assert property (p_bit_other) else $error("bit op no clear");
  property p_ext_clr;
    start_det || stop_det || exit_r |=> !extension_code_flag_r;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("extension flag kept");
  property p_ext_set;
    eighth && first_byte_r && addr_sh_r[6:3] == 4'hf && !start_det && !stop_det
      && !clr_common |=> extension_code_flag_r;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("extension flag missed");
  property p_match;
    $rose(address_match_flag_r) |-> $past(eighth) && $past(addr_sh_r[6:0]) == own_slave_address;
  endproperty
  a_match: assert property (p_match) else $error("match flag wrong");
  property p_wrel;
    transmit_state_flag_r && wrel_r && clk_cnt_r == isf_pkg::ACK_CLK
      |=> !transmit_state_flag_r ##1 !data_drive_en_r;
  endproperty
  a_wrel: assert property (p_wrel) else $error("wait release ignored");
  property p_sreq_read;
    cpu_rd && cpu_addr == isf_pkg::CONTROL_ADDR |=> !cpu_rdata_r[isf_pkg::STOPREQ_BIT];
  endproperty
  a_sreq_read: assert property (p_sreq_read) else $error("stop request read 1");
  property p_status_read;
    stat_rd |=> cpu_rdata_r == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_status_wr;
    cpu_wr && cpu_addr == isf_pkg::STATUS_ADDR && !cpu_rd && !enable_fall && !exit_r
      && !arb_lost && !start_det && !stop_det && !scl_rise && !start_generated
      && !wrel_r && !other_bit |=> $stable(status);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status changed by write");

  c_start: cover property (start_det ##[1:300] master_active_flag_r);
  c_ext: cover property ($rose(extension_code_flag_r));
  c_arb: cover property (arbitration_lost_flag_r ##1 stat_rd ##1 !arbitration_lost_flag_r);
  c_wrel: cover property (transmit_state_flag_r ##1 wrel_r ##1 !transmit_state_flag_r);
endmodule

/* File: isf_bus_peer.sv */
// Second I2C party that drives the serial clock and data lines
module isf_bus_peer (
  output logic scl_line,
  output logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 400;
  // Data hold after the clock fall, so data never moves while clock reads high
  localparam int HOLD_NS = 100;
  // Both lines released and pulled high between frames
  initial begin
    scl_line = 1'b1;
    sda_line = 1'b1;
  end
  // Start: data falls while clock is high
  task automatic start_cond();
    #37;
    sda_line = 1'b0;
    #HALF_NS;
    scl_line = 1'b0;
    #HALF_NS;
  endtask
  // Byte msb first, released ninth bit, clock then held low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      #HOLD_NS;
      sda_line = (i == 0) ? 1'b1 : b[i-1];
      #(HALF_NS - HOLD_NS);
      scl_line = 1'b1;
      #HALF_NS;
      scl_line = 1'b0;
    end
    #HALF_NS;
  endtask
  // Stop: data rises while clock is high
  task automatic stop_cond();
    sda_line = 1'b0;
    #HALF_NS;
    scl_line = 1'b1;
    #HALF_NS;
    sda_line = 1'b1;
    #HALF_NS;
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the I2C status flag block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] SA = isf_pkg::STATUS_ADDR;
  localparam logic [15:0] CA = isf_pkg::CONTROL_ADDR;
  logic core_clk, rstn, cpu_rd, cpu_wr, cpu_bit, start_generated, arb_lost;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, rv, cpu_rdata_r, e, a;
  logic stop_request_r, data_drive_en_r, enable_r, scl, sda;
  logic [6:0] own_slave_address;
  int mismatches, checked;
  logic [7:0] tab [5] = '{8'hf1, 8'h0b, 8'h55, 8'h81, 8'hf1};
  isf_status DUT (.core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata),
    .own_slave_address(own_slave_address), .start_generated(start_generated),
    .arb_lost(arb_lost), .scl_in(scl), .sda_in(sda), .cpu_rdata_r(cpu_rdata_r),
    .stop_request_r(stop_request_r), .data_drive_en_r(data_drive_en_r), .enable_r(enable_r));
  isf_bus_peer peer (.scl_line(scl), .sda_line(sda));
  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // One CPU access; read data lands in rv
  task automatic acc(input logic [15:0] ad, input logic rd, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    #10;
    cpu_addr = ad;
    cpu_rd = rd;
    cpu_wr = ~rd;
    cpu_wdata = d;
    cpu_bit = b;
    @(posedge core_clk);
    #10;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_bit = 1'b0;
    rv = cpu_rdata_r;
  endtask
  // One-cycle event pulses from the clock generator side
  task automatic ev(input logic s, input logic l);
    @(posedge core_clk);
    #10;
    start_generated = s;
    arb_lost = l;
    @(posedge core_clk);
    #10;
    start_generated = 1'b0;
    arb_lost = 1'b0;
  endtask
  // Byte comparison
  task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    {cpu_rd, cpu_wr, cpu_bit, start_generated, arb_lost} = 5'h00;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    own_slave_address = 7'h2a;
    rstn = 1'b0;
    repeat (12) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("status", isf_pkg::STATUS_RESET, rv);
    acc(SA, 1'b1, 8'h00, 1'b1); cmp("status bit", isf_pkg::STATUS_RESET, rv);
    acc(CA, 1'b0, 8'h80, 1'b0);
    cmp("enable on", 8'h01, {7'h00, enable_r});
    ev(1'b1, 1'b0);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("master", 8'h80, rv);
    acc(CA, 1'b0, 8'h81, 1'b0); cmp("stop req", 8'h01, {7'h00, stop_request_r});
    acc(CA, 1'b1, 8'h00, 1'b0); cmp("control", 8'h80, rv);
    ev(1'b0, 1'b1);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("arb", 8'h40, rv);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("arb read clr", 8'h00, rv);
    acc(SA, 1'b0, 8'hff, 1'b0);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("status wr", 8'h00, rv);
    ev(1'b0, 1'b1);
    acc(CA, 1'b0, 8'h80, 1'b1);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("arb bit op", 8'h00, rv);
    ev(1'b1, 1'b0);
    acc(CA, 1'b0, 8'hc0, 1'b0);
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("exit", 8'h00, rv);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    acc(CA, 1'b0, 8'h00, 1'b0);
    cmp("enable off", 8'h00, {7'h00, enable_r});
    acc(SA, 1'b1, 8'h00, 1'b0); cmp("disable", 8'h00, rv);
    acc(CA, 1'b0, 8'h01, 1'b0); cmp("stop refused", 8'h00, {7'h00, stop_request_r});
    acc(CA, 1'b0, 8'h80, 1'b0);
    // Address frames: extension, match, transmit state and their clears
    for (int i = 0; i < 5; i++) begin
      a = tab[i];
      e = {2'b00, a[7:4] == 4'h0 || a[7:4] == 4'hf, a[7:1] == own_slave_address,
        a[7:1] == own_slave_address && a[0], 3'b000};
      peer.start_cond();
      peer.send_byte(a);
      acc(SA, 1'b1, 8'h00, 1'b0); cmp("flags", e | 8'h02, rv);
      cmp("drive", {7'h00, e[3]}, {7'h00, data_drive_en_r});
      acc(CA, 1'b0, 8'ha0, 1'b0);
      acc(SA, 1'b1, 8'h00, 1'b0); cmp("released", (e & 8'hf0) | 8'h02, rv);
      cmp("drive off", 8'h00, {7'h00, data_drive_en_r});
      if (i == 4) begin
        acc(CA, 1'b0, 8'hc0, 1'b0);
      end else begin
        peer.stop_cond();
      end
      acc(SA, 1'b1, 8'h00, 1'b0); cmp("cleared", (i == 4) ? 8'h00 : 8'h01, rv);
      if (i == 4) begin
        peer.stop_cond();
      end
    end
    complete_run();
  end
endmodule
